// ===== rtl/rso_core.v
// Execution core for rotate-left-through-carry, two subtractions and sleep.
// Assumes one instruction per cycle on op_valid, file read data valid with it.
//
// Notes on behaviour
// - Rotate addressed file left; old carry enters bit 0, bit 7 becomes carry.
// - Sleep clears the power-down status flag.
// - Sleep sets the time-out flag and zeroes watchdog counter and prescaler.
// - After sleep the oscillator stops and execution halts.
// - Literal minus accumulator into accumulator; carry and half-borrow mean no borrow.
// - File minus accumulator to chosen destination; same carry and half-borrow.
`timescale 1ns/1ns
`include "rso_defines.vh"
module rso_core #(
  parameter AW = 7,
  parameter WDT_W = 8,
  parameter PRE_W = 8
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             op_valid,
  input  wire [2:0]       op_code,
  input  wire [7:0]       literal,
  input  wire [AW-1:0]    file_addr,
  input  wire             dest_sel,
  input  wire [7:0]       file_rdata,
  input  wire             wake,
  output reg  [7:0]       acc_q,
  output reg              file_we_q,
  output reg  [AW-1:0]    file_waddr_q,
  output reg  [7:0]       file_wdata_q,
  output reg              carry_q,
  output reg              half_borrow_flag_q,
  output reg              zero_q,
  output reg              sleep_entered_flag_q,
  output reg              expiry_flag_q,
  output reg  [WDT_W-1:0] watchdog_counter_q,
  output reg  [PRE_W-1:0] wdt_prescaler_q,
  output reg              osc_run_q,
  output reg              halted_q
);

  reg [7:0] res_d;
  reg [8:0] diff_d;
  reg [4:0] hdiff_d;
  reg [7:0] minuend_d;

  // Destination decode is shared by the rotate and the file subtraction.
  function dest_is_acc;
    input sel;
    begin
      dest_is_acc = (sel == `RSO_DEST_ACC);
    end
  endfunction

  // Subtraction is done as an unsigned 9-bit difference; no borrow means carry set.
  always @* begin
    minuend_d = (op_code == `RSO_OP_SUBLIT) ? literal : file_rdata;
    diff_d    = {1'b0, minuend_d} - {1'b0, acc_q};
    hdiff_d   = {1'b0, minuend_d[`RSO_NIB-1:0]} - {1'b0, acc_q[`RSO_NIB-1:0]};
    res_d     = diff_d[7:0];
    if (op_code == `RSO_OP_ROTATE) begin
      res_d = {file_rdata[`RSO_MSB-1:0], carry_q};
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      acc_q                <= `RSO_ACC_RST;
      file_we_q            <= 1'b0;
      file_waddr_q         <= {AW{1'b0}};
      file_wdata_q         <= `RSO_FILE_RST;
      carry_q              <= 1'b0;
      half_borrow_flag_q   <= 1'b0;
      zero_q               <= 1'b0;
      sleep_entered_flag_q <= 1'b1;
      expiry_flag_q        <= 1'b1;
      watchdog_counter_q   <= {WDT_W{1'b0}};
      wdt_prescaler_q      <= {PRE_W{1'b0}};
      osc_run_q            <= 1'b1;
      halted_q             <= 1'b0;
    end else begin
      file_we_q <= 1'b0;
      if (halted_q) begin
        // Halted core ignores instructions until woken from outside.
        if (wake) begin
          halted_q  <= 1'b0;
          osc_run_q <= 1'b1;
        end
      end else if (op_valid) begin
        case (op_code)
          `RSO_OP_ROTATE: begin
            carry_q <= file_rdata[`RSO_MSB];
            if (dest_is_acc(dest_sel)) begin
              acc_q <= res_d;
            end else begin
              file_we_q    <= 1'b1;
              file_waddr_q <= file_addr;
              file_wdata_q <= res_d;
            end
          end
          `RSO_OP_SUBLIT: begin
            acc_q              <= res_d;
            carry_q            <= ~diff_d[8];
            half_borrow_flag_q <= ~hdiff_d[4];
            zero_q             <= (res_d == `RSO_ZERO8);
          end
          `RSO_OP_SUBFILE: begin
            carry_q            <= ~diff_d[8];
            half_borrow_flag_q <= ~hdiff_d[4];
            zero_q             <= (res_d == `RSO_ZERO8);
            if (dest_is_acc(dest_sel)) begin
              acc_q <= res_d;
            end else begin
              file_we_q    <= 1'b1;
              file_waddr_q <= file_addr;
              file_wdata_q <= res_d;
            end
          end
          `RSO_OP_SLEEP: begin
            sleep_entered_flag_q <= 1'b0;
            expiry_flag_q        <= 1'b1;
            // Widths follow the parameters, so zero is built at the parameter width.
            watchdog_counter_q   <= {WDT_W{1'b0}};
            wdt_prescaler_q      <= {PRE_W{1'b0}};
            osc_run_q            <= 1'b0;
            halted_q             <= 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
  end

endmodule // rso_core

// ===== rtl/rso_defines.vh
// Constants for the rotate, subtract and sleep execution block.
// Assumes inclusion by rtl/rso_core.v only.
`ifndef RSO_DEFINES_VH
`define RSO_DEFINES_VH
`define RSO_OP_NONE    3'h0
`define RSO_OP_ROTATE  3'h1
`define RSO_OP_SUBLIT  3'h2
`define RSO_OP_SUBFILE 3'h3
`define RSO_OP_SLEEP   3'h4
`define RSO_DEST_ACC   1'h0
`define RSO_DEST_FILE  1'h1
`define RSO_ZERO8      8'h00
`define RSO_MSB        7
`define RSO_NIB        4
`define RSO_WDT_ZERO   8'h00
`define RSO_PRE_ZERO   8'h00
`define RSO_ACC_RST    8'h00
`define RSO_FILE_RST   8'h00
`endif

// ===== tb/rso_chk_checker.sv
// Port checker for rso_core, bound to every instance.
`timescale 1ns/1ns
module rso_chk (
  input wire       clk,
  input wire       rst_n,
  input wire       op_valid,
  input wire [2:0] op_code,
  input wire [7:0] literal,
  input wire [7:0] file_rdata,
  input wire       half_borrow_flag_q,
  input wire       dest_sel,
  input wire [7:0] acc_q,
  input wire       file_we_q,
  input wire       carry_q,
  input wire       zero_q,
  input wire       sleep_entered_flag_q,
  input wire       expiry_flag_q,
  input wire       osc_run_q,
  input wire       halted_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire go = op_valid && !halted_q;
  wire sl = go && op_code == 3'h4;
  wire sb = go && op_code == 3'h2;
  wire rt = go && op_code == 3'h1;
  wire sf = go && op_code == 3'h3;
  pd_clear_a: assert property (sl |=> !sleep_entered_flag_q) else $error("pd");
  to_set_a: assert property (sl |=> expiry_flag_q) else $error("to");
  halt_stop_a: assert property (sl |=> halted_q && !osc_run_q) else $error("halt");
  lit_diff_a: assert property (sb |=> acc_q == $past(literal) - $past(acc_q))
    else $error("diff");
  lit_carry_a: assert property (sb |=> carry_q == ($past(acc_q) <= $past(literal)))
    else $error("carry");
  dest_acc_a: assert property (sf && !dest_sel |=> !file_we_q) else $error("we");
  rot_keep_a: assert property (rt |=> $stable(zero_q)) else $error("z kept");
  sub_zero_a: assert property (sb |=> zero_q == (acc_q == 8'h00)) else $error("z");
  rot_carry_a: assert property (rt |=> carry_q == $past(file_rdata[7]))
    else $error("rot carry");
  lit_half_a: assert property (sb |=> half_borrow_flag_q ==
    ($past(acc_q[3:0]) <= $past(literal[3:0]))) else $error("half");
endmodule // rso_chk
bind rso_core rso_chk rso_chk_inst (.clk(clk), .rst_n(rst_n), .op_valid(op_valid),
  .op_code(op_code), .literal(literal), .dest_sel(dest_sel), .acc_q(acc_q),
  .file_rdata(file_rdata), .half_borrow_flag_q(half_borrow_flag_q),
  .file_we_q(file_we_q), .carry_q(carry_q), .zero_q(zero_q), .osc_run_q(osc_run_q),
  .sleep_entered_flag_q(sleep_entered_flag_q), .expiry_flag_q(expiry_flag_q),
  .halted_q(halted_q));

// ===== tb/tb.sv
// Bench for rso_core; the file address follows each operand so write-back is traced.
`timescale 1ns/1ns
`define CK(a,b) begin n_checks++; if ((a)!==(b)) begin errors++; \
  $display("wrong value %0t %h %h", $time, a, b); end end
module tb;
  reg        clk, rst_n, v, d, wake;
  reg  [2:0] c;
  reg  [7:0] k, f;
  reg  [6:0] fa;
  wire [6:0] wa;
  wire [7:0] a, fw, wd, pr;
  wire       we, cy, hb, z, pd, to, osc, h;
  integer    errors = 0, n_checks = 0, cyc = 0;
  rso_core rso_core_inst (.clk(clk), .rst_n(rst_n), .op_valid(v), .op_code(c), .literal(k),
    .file_addr(fa), .dest_sel(d), .file_rdata(f), .wake(wake), .acc_q(a), .file_we_q(we),
    .file_waddr_q(wa), .file_wdata_q(fw), .carry_q(cy), .half_borrow_flag_q(hb), .zero_q(z),
    .sleep_entered_flag_q(pd), .expiry_flag_q(to), .watchdog_counter_q(wd),
    .wdt_prescaler_q(pr), .osc_run_q(osc), .halted_q(h));
  task op(input [2:0] oc, input [7:0] kk, input [7:0] ff, input dd); begin
    @(posedge clk); v <= 1; c <= oc; k <= kk; f <= ff; d <= dd;
    fa <= ff[6:0] ^ 7'h2a;
    @(posedge clk); v <= 0; #1;
  end endtask
  task sub_t; begin
    op(3'h2, 8'h05, 8'h00, 0); `CK({a, cy, hb, z}, {8'h05, 3'b110})
    op(3'h2, 8'h03, 8'h00, 0); `CK({a, cy, hb, z}, {8'hfe, 3'b000})
    op(3'h3, 8'h00, 8'hfe, 1); `CK({we, fw, a, cy, hb, z}, {9'h100, 8'hfe, 3'b111})
    `CK(wa, 7'h54)
    op(3'h3, 8'h00, 8'h10, 0); `CK({we, a, cy, hb, z}, {9'h012, 3'b000})
  end endtask
  task rot_t; begin
    op(3'h1, 8'h00, 8'he6, 0); `CK({a, cy, hb, z}, {8'hcc, 3'b100})
    op(3'h1, 8'h00, 8'h80, 1); `CK({we, fw, cy, a}, {9'h101, 1'b1, 8'hcc})
    `CK(wa, 7'h2a)
    op(3'h0, 8'h99, 8'h99, 1); `CK({we, a, cy}, {9'h0cc, 1'b1})
  end endtask
  task sleep_t; begin
    op(3'h4, 8'h00, 8'h00, 0); `CK({pd, to, wd, pr, osc, h}, {2'b01, 16'h0, 2'b01})
    op(3'h2, 8'h77, 8'h00, 0); `CK({a, h}, {8'hcc, 1'b1})
    @(posedge clk); wake <= 1;
    @(posedge clk); wake <= 0; #1; `CK(h, 1'b0)
  end endtask
  task rst_t; begin
    @(posedge clk); rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1; #1; `CK({pd, to, osc, h, a}, {4'b1110, 8'h00})
    op(3'h2, 8'h00, 8'h00, 0); `CK({a, cy, hb, z}, {8'h00, 3'b111})
  end endtask
  task results; begin
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  end endtask
  initial begin clk = 0; forever #25 clk = ~clk; end
  // A hang in a wait would otherwise never reach the verdict.
  always @(posedge clk) begin cyc <= cyc + 1; if (cyc == 400) begin errors++; results; end end
  initial begin
    rst_n = 0; v = 0; c = 0; k = 0; f = 0; d = 0; wake = 0; fa = 7'h2a;
    repeat (16) @(posedge clk);
    rst_n <= 1; #1; `CK({pd, to, osc}, 3'b111)
    sub_t; rot_t; sleep_t; rst_t; results;
  end
endmodule // tb
